// ===== hdl/dig_pkg.sv
// Package with the register map, field layout and reset values of the interrupt generators.
package dig_pkg;

  // Source count and pulse length width.
  localparam int unsigned DIG_NSRC = 6;
  localparam int unsigned DIG_LEN_W = 8;

  // Source bit positions, shared by enables, status and live copies.
  localparam int unsigned DIG_SRC_SAMPLE = 0;
  localparam int unsigned DIG_SRC_FIFO_RDY = 1;
  localparam int unsigned DIG_SRC_FIFO_THR = 2;
  localparam int unsigned DIG_SRC_FIFO_OVR = 3;
  localparam int unsigned DIG_SRC_STARTUP = 4;
  localparam int unsigned DIG_SRC_SYNC = 5;

  // Byte offsets of the registers.
  localparam logic [7:0] DIG_OFF_CFG_A = 8'h00;
  localparam logic [7:0] DIG_OFF_CFG_B = 8'h04;
  localparam logic [7:0] DIG_OFF_STAT_A = 8'h08;
  localparam logic [7:0] DIG_OFF_STAT_B = 8'h0c;
  localparam logic [7:0] DIG_OFF_LIVE = 8'h10;
  localparam logic [7:0] DIG_OFF_PWR = 8'h14;
  localparam logic [7:0] DIG_OFF_SYS_STAT = 8'h18;
  localparam logic [7:0] DIG_OFF_SYS_MASK = 8'h1c;

  // Generator configuration fields.
  localparam int unsigned DIG_CFG_EN_LSB = 0;
  localparam int unsigned DIG_CFG_MODE_LSB = 6;
  localparam int unsigned DIG_CFG_CLRW_BIT = 8;
  localparam int unsigned DIG_CFG_POL_BIT = 9;
  localparam int unsigned DIG_CFG_LEN_LSB = 16;

  // Output behaviour codes of a generator.
  localparam logic [1:0] DIG_MODE_LATCHED = 2'h0;
  localparam logic [1:0] DIG_MODE_UNLATCHED = 2'h1;
  localparam logic [1:0] DIG_MODE_TIMED = 2'h2;

  // Power control fields.
  localparam int unsigned DIG_PWR_MODE_LSB = 0;
  localparam int unsigned DIG_PWR_AUTO_BIT = 2;
  localparam int unsigned DIG_PWR_LEVEL_BIT = 3;
  localparam int unsigned DIG_PWR_LOW_BIT = 4;
  localparam int unsigned DIG_PWR_TGT_LSB = 5;

  // System event bits.
  localparam int unsigned DIG_SYS_WAKE = 0;
  localparam int unsigned DIG_SYS_LINE_A = 1;
  localparam int unsigned DIG_SYS_LINE_B = 2;
  localparam int unsigned DIG_SYS_W = 3;

  // Reset values.
  localparam logic [31:0] DIG_CFG_RST = 32'h0001_0200;
  localparam logic [DIG_SYS_W-1:0] DIG_SYS_RST = 3'h0;

  // Power states; standby and power-down keep the register file alive.
  typedef enum logic [1:0] {DIG_PWR_NORMAL, DIG_PWR_STANDBY, DIG_PWR_DOWN} dig_pwr_e;

endpackage

// ===== hdl/dig_line.sv
// One interrupt generator: latched status, clear handling and the output line.
`timescale 1ns/1ps
module dig_line
  import dig_pkg::*;
#(
  parameter int LEN_W = DIG_LEN_W
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [DIG_NSRC-1:0] cond,
  input wire logic [DIG_NSRC-1:0] src_en,
  input wire logic [1:0] mode,
  input wire logic clr_on_wr,
  input wire logic act_high,
  input wire logic [LEN_W-1:0] pulse_len,
  input wire logic rd_clr,
  input wire logic wr_clr,
  input wire logic [DIG_NSRC-1:0] wr_mask,
  output logic [DIG_NSRC-1:0] latched,
  output logic line
);

  logic [DIG_NSRC-1:0] cond_q_reg;
  logic [DIG_NSRC-1:0] new_evt;
  logic [DIG_NSRC-1:0] clr_bits;
  logic [LEN_W-1:0] cnt_reg;
  logic active;

  // An event is a rising edge of an enabled condition.
  assign new_evt = cond & src_en & ~cond_q_reg;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cond_q_reg <= '0;
    else
      cond_q_reg <= cond;
  end

  // Only the selected clearing method has effect; the other one is ignored.
  always_comb
  begin
    clr_bits = '0;
    if (rd_clr && !clr_on_wr)
      clr_bits = '1;
    else if (wr_clr && clr_on_wr)
      clr_bits = wr_mask;
  end

  // A new event wins over a clear landing in the same cycle.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      latched <= '0;
    else
      latched <= (latched & ~clr_bits) | new_evt;
  end

  // Pulse timer; a programmed length of zero still gives one cycle.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cnt_reg <= '0;
    else if (mode == DIG_MODE_TIMED && |new_evt)
      cnt_reg <= (pulse_len == '0) ? LEN_W'(1) : pulse_len;
    else if (cnt_reg != '0)
      cnt_reg <= cnt_reg - LEN_W'(1);
  end

  // Output behaviour per mode.
  always_comb
  begin
    case (mode)
      DIG_MODE_LATCHED: active = |(latched & src_en);
      DIG_MODE_UNLATCHED: active = |(cond & src_en);
      DIG_MODE_TIMED: active = (cnt_reg != '0);
      default: active = 1'b0;
    endcase
  end

  // Registered pin level with selectable polarity.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      line <= 1'b0;
    else
      line <= act_high ? active : ~active;
  end

endmodule

// ===== hdl/dig_top.sv
// Dual interrupt generator with AHB-Lite register access and sync pin power control.
// What this block does
// - Two independent generators, each own line.
// - Each line assigned its own events.
// - Configurable polarity, duration, clearing, trigger set.
// - Status offered latched and live.
// - Per-source enable and clear.
// - Six sources including sync pin.
// - Latched, unlatched or timed output modes.
// - Clear-on-read clears latched status.
// - Clear-on-write clears only masked bits.
// - Sync pin wakes and aligns capture.
// - Registers accessible in every power mode.
// - Power mode by software or sync.
`timescale 1ns/1ps
module dig_top
  import dig_pkg::*;
#(
  parameter int LEN_W = DIG_LEN_W
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic sample_ready,
  input wire logic fifo_ready,
  input wire logic fifo_threshold,
  input wire logic fifo_overrun,
  input wire logic startup_done,
  input wire logic sync_wake_pin,
  output logic irq_line_a,
  output logic irq_line_b,
  output logic irq,
  output logic [1:0] power_mode,
  output logic sync_capture
);

  // Bus bookkeeping.
  logic acc;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic wr_en;

  // Generator configuration and status.
  logic [31:0] cfg_reg [2];
  logic [DIG_NSRC-1:0] stat [2];
  logic [1:0] rd_clr;
  logic [1:0] wr_clr;
  logic [1:0] lines;
  logic [1:0] lines_q_reg;
  logic [1:0] pol_q_reg;
  logic [DIG_NSRC-1:0] cond;

  // Sync pin path.
  logic sync_s1_reg;
  logic sync_s2_reg;
  logic sync_s3_reg;
  logic sync_lvl_reg;
  logic sync_lvl_q_reg;
  logic sync_act;
  logic sync_act_q;
  logic sync_rise;
  logic sync_fall;
  logic sync_evt;

  // Power control.
  dig_pwr_e pwr_reg;
  logic auto_reg;
  logic level_reg;
  logic low_reg;
  logic [1:0] tgt_reg;

  // System interrupt.
  logic [DIG_SYS_W-1:0] sys_stat_reg;
  logic [DIG_SYS_W-1:0] sys_mask_reg;
  logic [DIG_SYS_W-1:0] sys_evt;
  logic [DIG_SYS_W-1:0] sys_clr;
  logic irq_reg;

  // Read path.
  logic [31:0] rd_mux;
  logic [31:0] hrdata_reg;

  // Zero wait state slave; every answer is OKAY, unmapped reads give zero.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;

  // Only a selected NONSEQ or SEQ transfer with the bus ready is taken.
  assign acc = hsel && hready && htrans[1];

  // A write address is held until its data phase.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end
    else if (hready)
    begin
      wr_pend_reg <= acc && hwrite;
      wr_addr_reg <= haddr[7:0];
    end
  end

  // Write strobe in the data phase; no power mode gates it.
  assign wr_en = wr_pend_reg;

  // Live conditions; the sync bit is the filtered pin level after the polarity select.
  assign cond[DIG_SRC_SAMPLE] = sample_ready;
  assign cond[DIG_SRC_FIFO_RDY] = fifo_ready;
  assign cond[DIG_SRC_FIFO_THR] = fifo_threshold;
  assign cond[DIG_SRC_FIFO_OVR] = fifo_overrun;
  assign cond[DIG_SRC_STARTUP] = startup_done;
  assign cond[DIG_SRC_SYNC] = sync_act;

  // Three-stage synchroniser; the level only changes when stages two and three agree.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync_s1_reg <= 1'b0;
      sync_s2_reg <= 1'b0;
      sync_s3_reg <= 1'b0;
    end
    else
    begin
      sync_s1_reg <= sync_wake_pin;
      sync_s2_reg <= sync_s1_reg;
      sync_s3_reg <= sync_s2_reg;
    end
  end

  // Filtered level and its previous value for edge detection.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync_lvl_reg <= 1'b0;
      sync_lvl_q_reg <= 1'b0;
    end
    else
    begin
      if (sync_s2_reg == sync_s3_reg)
        sync_lvl_reg <= sync_s3_reg;
      sync_lvl_q_reg <= sync_lvl_reg;
    end
  end

  // Polarity and edge or level selection for the sync pin.
  assign sync_act = sync_lvl_reg ^ low_reg;
  assign sync_act_q = sync_lvl_q_reg ^ low_reg;
  assign sync_rise = sync_act && !sync_act_q;
  assign sync_fall = !sync_act && sync_act_q;
  assign sync_evt = level_reg ? sync_act : sync_rise;

  // One pulse per active edge tells the sampler to capture now.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sync_capture <= 1'b0;
    else
      sync_capture <= sync_rise;
  end

  // Generator configuration registers, one per line.
  generate
    for (genvar g = 0; g < 2; g++)
    begin : gen_line
      logic [7:0] cfg_off;
      logic [7:0] stat_off;

      assign cfg_off = (g == 0) ? DIG_OFF_CFG_A : DIG_OFF_CFG_B;
      assign stat_off = (g == 0) ? DIG_OFF_STAT_A : DIG_OFF_STAT_B;

      // Software owns the whole configuration word.
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          cfg_reg[g] <= DIG_CFG_RST;
        else if (wr_en && wr_addr_reg == cfg_off)
          cfg_reg[g] <= hwdata;
      end

      // A status read clears at the address edge, so the read still sees the old value.
      assign rd_clr[g] = acc && !hwrite && haddr[7:0] == stat_off;
      assign wr_clr[g] = wr_en && wr_addr_reg == stat_off;

      // Each generator sees the same conditions through its own enables.
      dig_line #(
        .LEN_W(LEN_W)
      ) u_line (
        .hclk(hclk),
        .hresetn(hresetn),
        .cond(cond),
        .src_en(cfg_reg[g][DIG_CFG_EN_LSB +: DIG_NSRC]),
        .mode(cfg_reg[g][DIG_CFG_MODE_LSB +: 2]),
        .clr_on_wr(cfg_reg[g][DIG_CFG_CLRW_BIT]),
        .act_high(cfg_reg[g][DIG_CFG_POL_BIT]),
        .pulse_len(cfg_reg[g][DIG_CFG_LEN_LSB +: LEN_W]),
        .rd_clr(rd_clr[g]),
        .wr_clr(wr_clr[g]),
        .wr_mask(hwdata[DIG_NSRC-1:0]),
        .latched(stat[g]),
        .line(lines[g])
      );
    end
  endgenerate

  assign irq_line_a = lines[0];
  assign irq_line_b = lines[1];

  // Power mode settings that software owns.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      auto_reg <= 1'b0;
      level_reg <= 1'b0;
      low_reg <= 1'b0;
      tgt_reg <= 2'h0;
    end
    else if (wr_en && wr_addr_reg == DIG_OFF_PWR)
    begin
      auto_reg <= hwdata[DIG_PWR_AUTO_BIT];
      level_reg <= hwdata[DIG_PWR_LEVEL_BIT];
      low_reg <= hwdata[DIG_PWR_LOW_BIT];
      tgt_reg <= hwdata[DIG_PWR_TGT_LSB +: 2];
    end
  end

  // Power state: a sync wake wins over a software write in the same cycle,
  // and the reserved mode code is ignored so the state never leaves the enum.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pwr_reg <= DIG_PWR_NORMAL;
    else if (auto_reg && sync_evt && pwr_reg != DIG_PWR_NORMAL)
      pwr_reg <= DIG_PWR_NORMAL;
    else if (auto_reg && sync_fall && !level_reg)
    begin
      case (tgt_reg)
        2'h1: pwr_reg <= DIG_PWR_STANDBY;
        2'h2: pwr_reg <= DIG_PWR_DOWN;
        default: pwr_reg <= pwr_reg;
      endcase
    end
    else if (wr_en && wr_addr_reg == DIG_OFF_PWR)
    begin
      case (hwdata[DIG_PWR_MODE_LSB +: 2])
        2'h0: pwr_reg <= DIG_PWR_NORMAL;
        2'h1: pwr_reg <= DIG_PWR_STANDBY;
        2'h2: pwr_reg <= DIG_PWR_DOWN;
        default: pwr_reg <= pwr_reg;
      endcase
    end
  end

  assign power_mode = pwr_reg;

  // Rising edges of the two lines, seen as asserted whatever the polarity.
  // The polarity is delayed along with the pin, so a polarity write alone is no edge.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pol_q_reg <= {2{DIG_CFG_RST[DIG_CFG_POL_BIT]}};
      lines_q_reg <= 2'h0;
    end
    else
    begin
      pol_q_reg <= {cfg_reg[1][DIG_CFG_POL_BIT], cfg_reg[0][DIG_CFG_POL_BIT]};
      lines_q_reg <= lines ^ ~pol_q_reg;
    end
  end

  // System events: wakes and assertions of either line.
  always_comb
  begin
    sys_evt = '0;
    sys_evt[DIG_SYS_WAKE] = auto_reg && sync_evt && pwr_reg != DIG_PWR_NORMAL;
    sys_evt[DIG_SYS_LINE_A] = (lines[0] ^ ~pol_q_reg[0]) && !lines_q_reg[0];
    sys_evt[DIG_SYS_LINE_B] = (lines[1] ^ ~pol_q_reg[1]) && !lines_q_reg[1];
  end

  // Writing a one clears a system status bit.
  assign sys_clr = (wr_en && wr_addr_reg == DIG_OFF_SYS_STAT) ? hwdata[DIG_SYS_W-1:0] : '0;

  // Sticky status; an event in the clearing cycle survives.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sys_stat_reg <= DIG_SYS_RST;
    else
      sys_stat_reg <= (sys_stat_reg & ~sys_clr) | sys_evt;
  end

  // Mask register gating the system status onto the interrupt output.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sys_mask_reg <= DIG_SYS_RST;
    else if (wr_en && wr_addr_reg == DIG_OFF_SYS_MASK)
      sys_mask_reg <= hwdata[DIG_SYS_W-1:0];
  end

  // The output lags the status by one cycle to keep it glitch free.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_reg <= 1'b0;
    else
      irq_reg <= |(sys_stat_reg & sys_mask_reg);
  end

  assign irq = irq_reg;

  // Read decode on the address phase.
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (haddr[7:0])
      DIG_OFF_CFG_A: rd_mux = cfg_reg[0];
      DIG_OFF_CFG_B: rd_mux = cfg_reg[1];
      DIG_OFF_STAT_A: rd_mux[DIG_NSRC-1:0] = stat[0];
      DIG_OFF_STAT_B: rd_mux[DIG_NSRC-1:0] = stat[1];
      DIG_OFF_LIVE: rd_mux[DIG_NSRC-1:0] = cond;
      DIG_OFF_PWR:
      begin
        rd_mux[DIG_PWR_MODE_LSB +: 2] = pwr_reg;
        rd_mux[DIG_PWR_AUTO_BIT] = auto_reg;
        rd_mux[DIG_PWR_LEVEL_BIT] = level_reg;
        rd_mux[DIG_PWR_LOW_BIT] = low_reg;
        rd_mux[DIG_PWR_TGT_LSB +: 2] = tgt_reg;
      end
      DIG_OFF_SYS_STAT: rd_mux[DIG_SYS_W-1:0] = sys_stat_reg;
      DIG_OFF_SYS_MASK: rd_mux[DIG_SYS_W-1:0] = sys_mask_reg;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data is captured at the address edge and stands through the data phase.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_reg <= 32'h0000_0000;
    else if (acc && !hwrite)
      hrdata_reg <= rd_mux;
  end

endmodule

// ===== tb/dig_assertions.sv
// Checker for the dual interrupt generator, watching only the top ports.
`timescale 1ns/1ps
module dig_assertions
  import dig_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic sample_ready,
  input wire logic fifo_ready,
  input wire logic fifo_threshold,
  input wire logic fifo_overrun,
  input wire logic startup_done,
  input wire logic irq_line_a,
  input wire logic irq_line_b,
  input wire logic [1:0] power_mode,
  input wire logic sync_capture
);
  logic [31:0] cfg_a;
  logic [31:0] cfg_b;
  logic [7:0] ph_addr;
  logic ph_wr;
  logic [3:0] quiet;
  logic [DIG_NSRC-1:0] cond;
  logic act_a;
  logic act_b;

  // Live sources without sync; the two unlatched checks that lean on them exclude the sync enable.
  assign cond = {1'b0, startup_done, fifo_overrun, fifo_threshold, fifo_ready, sample_ready};
  assign act_a = irq_line_a == cfg_a[DIG_CFG_POL_BIT];
  assign act_b = irq_line_b == cfg_b[DIG_CFG_POL_BIT];

  // Shadow of both configuration words, rebuilt from the writes seen on the bus.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg_a <= DIG_CFG_RST;
      cfg_b <= DIG_CFG_RST;
      ph_wr <= 1'b0;
      ph_addr <= 8'h00;
    end
    else
    begin
      ph_wr <= hsel && hready && htrans[1] && hwrite;
      ph_addr <= haddr[7:0];
      if (ph_wr && ph_addr == DIG_OFF_CFG_A)
        cfg_a <= hwdata;
      if (ph_wr && ph_addr == DIG_OFF_CFG_B)
        cfg_b <= hwdata;
    end
  end

  // Cycles since the last transfer, so that clears and new settings have landed first.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      quiet <= 4'h0;
    else if (hsel && hready && htrans[1])
      quiet <= 4'h0;
    else if (quiet != 4'hf)
      quiet <= quiet + 4'h1;
  end

  default clocking dig_cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_bus_ready:
    assert property (hreadyout && !hresp) else $error("bus stalled or errored");
  a_pwr_legal:
    assert property (power_mode != 2'h3) else $error("illegal power state");
  a_capture_pulse:
    assert property (sync_capture |=> !sync_capture) else $error("capture pulse too long");
  a_unlatched_a:
    assert property (quiet > 4'h2 && cfg_a[7:6] == DIG_MODE_UNLATCHED && !cfg_a[5]
      |-> act_a == |($past(cond) & cfg_a[5:0])) else $error("line a not following sources");
  a_unlatched_b:
    assert property (quiet > 4'h2 && cfg_b[7:6] == DIG_MODE_UNLATCHED && !cfg_b[5]
      |-> act_b == |($past(cond) & cfg_b[5:0])) else $error("line b not following sources");
  a_idle_level_b:
    assert property (quiet > 4'h2 && cfg_b[7:6] != DIG_MODE_TIMED && cfg_b[5:0] == 6'h00
      |-> !act_b) else $error("line b active with no source enabled");
  a_latched_hold:
    assert property (quiet > 4'h2 && cfg_a[7:6] == DIG_MODE_LATCHED && act_a |=> act_a)
      else $error("latched line a dropped without a clear");
  a_latched_rise:
    assert property (quiet > 4'h3 && cfg_a[7:6] == DIG_MODE_LATCHED
      && |(cond & ~$past(cond) & cfg_a[5:0]) |-> ##[1:3] act_a)
      else $error("latched line a missed an event");
endmodule

// ===== tb/dig_host.sv
// Host model: a single-transfer bus master that reads and writes the registers.
`timescale 1ns/1ps
module dig_host
  import dig_pkg::*;
(
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  output logic rd_done,
  output logic [31:0] rd_data,
  output logic hung
);
  // The bus idles until the first task call.
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    rd_done = 1'b0;
    rd_data = 32'h0;
    hung = 1'b0;
  end

  // Waits for ready at a rising edge; the bound keeps a stuck slave from hanging the run.
  task automatic wait_ready();
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (!hready && n < 16);
    if (!hready)
      hung <= 1'b1;
  endtask

  // One word transfer; read data is taken at the edge that closes the data phase.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    hwdata <= ~d;
    if (!wr)
    begin
      rd_data <= hrdata;
      rd_done <= 1'b1;
    end
  endtask

  // The done flag lasts one cycle so each read is seen once.
  always @(posedge hclk)
    if (rd_done)
      rd_done <= 1'b0;
endmodule

// ===== tb/testbench.sv
// Testbench: drives the generators through the host model and checks queued notes.
`timescale 1ns/1ps
module testbench
  import dig_pkg::*;
;
  typedef struct {string n; logic [31:0] v;} dig_note_s;
  dig_note_s notes[$];
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [4:0] src = 5'h0;
  logic sync_pin = 1'b0;
  logic probe = 1'b0;
  logic [31:0] meas = 32'h0;
  int fail_count = 0;
  int checked = 0;
  int seed = 95181;
  logic hsel, hwrite, hready, hresp, rd_done, hung, irq_line_a, irq_line_b, irq, sync_capture;
  logic [31:0] haddr, hwdata, hrdata, rd_data;
  logic [1:0] htrans, power_mode;
  logic [2:0] hsize;

  always #50 hclk = ~hclk;

  dig_top dig_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .sample_ready(src[0]),
    .fifo_ready(src[1]), .fifo_threshold(src[2]), .fifo_overrun(src[3]),
    .startup_done(src[4]), .sync_wake_pin(sync_pin), .irq_line_a(irq_line_a),
    .irq_line_b(irq_line_b), .irq(irq), .power_mode(power_mode), .sync_capture(sync_capture));
  dig_host dig_host_i (.hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .rd_done(rd_done), .rd_data(rd_data), .hung(hung));

  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Watcher: each finished read or probe takes the oldest note; a hung bus ends the run.
  always @(posedge hclk)
  begin
    dig_note_s e;
    if (rd_done && notes.size() > 0)
    begin
      e = notes.pop_front();
      check(e.n, rd_data, e.v);
    end
    if (probe && notes.size() > 0)
    begin
      e = notes.pop_front();
      check(e.n, meas, e.v);
    end
    if (hung)
    begin
      fail_count++;
      print_verdict();
    end
  end

  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] v);
    notes.push_back('{n, v});
    dig_host_i.xfer(1'b0, a, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    dig_host_i.xfer(1'b1, a, d);
  endtask

  task automatic show(input string n, input logic [31:0] seen, input logic [31:0] v);
    notes.push_back('{n, v});
    meas <= seen;
    probe <= 1'b1;
    @(posedge hclk);
    probe <= 1'b0;
  endtask

  // Pins are packed as irq, line b, line a.
  task automatic look(input string n, input logic [2:0] v);
    show(n, {29'h0, irq, irq_line_b, irq_line_a}, {29'h0, v});
  endtask

  initial
  begin
    logic [31:0] r;
    logic [4:0] m;
    logic [4:0] k;
    logic [7:0] len;
    int cnt;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset values, unmapped space and register access while powered down.
    rd("cfg_a", DIG_OFF_CFG_A, DIG_CFG_RST);
    rd("cfg_b", DIG_OFF_CFG_B, DIG_CFG_RST);
    rd("unmapped", 8'h40, 32'h0);
    wr(DIG_OFF_PWR, 32'h2);
    rd("pwr down", DIG_OFF_PWR, 32'h2);
    r = $random(seed) & 32'h00ff_03ff;
    wr(DIG_OFF_CFG_B, r);
    rd("cfg in sleep", DIG_OFF_CFG_B, r);
    wr(DIG_OFF_PWR, 32'h0);
    $display("test access done");
    // Each of the five non-sync sources latches on line A only; a status read returns and clears it.
    wr(DIG_OFF_CFG_A, 32'h0001_021f);
    wr(DIG_OFF_CFG_B, DIG_CFG_RST);
    for (int i = 0; i < 5; i++)
    begin
      src[i] <= 1'b1;
      repeat (4) @(posedge hclk);
      look("latched line", 3'h1);
      rd("live", DIG_OFF_LIVE, 32'h1 << i);
      rd("stat_a", DIG_OFF_STAT_A, 32'h1 << i);
      repeat (3) @(posedge hclk);
      look("read cleared", 3'h0);
      src[i] <= 1'b0;
      @(posedge hclk);
    end
    $display("test clear on read done");
    // Write-one clear removes only the written bits; reads leave status alone.
    wr(DIG_OFF_CFG_A, 32'h0001_031f);
    r = $random(seed);
    m = r[4:0] | 5'h01;
    k = m & (~m + 5'h01);
    src <= m;
    repeat (4) @(posedge hclk);
    src <= 5'h0;
    rd("cow stat", DIG_OFF_STAT_A, {27'h0, m});
    rd("cow kept", DIG_OFF_STAT_A, {27'h0, m});
    wr(DIG_OFF_STAT_A, {27'h0, k});
    rd("cow one", DIG_OFF_STAT_A, {27'h0, m & ~k});
    wr(DIG_OFF_STAT_A, {27'h0, m});
    repeat (3) @(posedge hclk);
    look("cow cleared", 3'h0);
    $display("test clear on write done");
    // Unlatched lines follow the threshold level, line B active low.
    wr(DIG_OFF_CFG_A, 32'h0001_0244);
    wr(DIG_OFF_CFG_B, 32'h0001_0044);
    repeat (3) @(posedge hclk);
    look("unlatched idle", 3'h2);
    src[2] <= 1'b1;
    repeat (3) @(posedge hclk);
    look("unlatched on", 3'h1);
    src[2] <= 1'b0;
    repeat (3) @(posedge hclk);
    look("unlatched off", 3'h2);
    $display("test unlatched done");
    // Timed pulse length, with zero length as the boundary case.
    wr(DIG_OFF_CFG_B, DIG_CFG_RST);
    for (int j = 0; j < 2; j++)
    begin
      r = $random(seed);
      len = (j == 0) ? 8'h0 : {5'h0, r[2:0]} + 8'h2;
      wr(DIG_OFF_CFG_A, {8'h0, len, 16'h0282});
      repeat (3) @(posedge hclk);
      src[1] <= 1'b1;
      @(posedge hclk);
      src[1] <= 1'b0;
      cnt = 0;
      repeat (16)
      begin
        @(posedge hclk);
        cnt += (irq_line_a === 1'b1);
      end
      show("pulse len", cnt, (len == 8'h0) ? 32'h1 : {24'h0, len});
    end
    $display("test timed done");
    // Sync wake from power-down: masked first, then unmasked, cleared, back to sleep.
    wr(DIG_OFF_SYS_STAT, 32'h7);
    wr(DIG_OFF_PWR, 32'h46);
    repeat (2) @(posedge hclk);
    sync_pin <= 1'b1;
    cnt = 0;
    repeat (10)
    begin
      @(posedge hclk);
      cnt += (sync_capture === 1'b1);
    end
    show("capture", cnt, 32'h1);
    rd("woken", DIG_OFF_PWR, 32'h44);
    rd("live sync", DIG_OFF_LIVE, 32'h20);
    look("masked", 3'h0);
    wr(DIG_OFF_SYS_MASK, 32'h1);
    repeat (2) @(posedge hclk);
    look("unmasked", 3'h4);
    wr(DIG_OFF_SYS_STAT, 32'h1);
    repeat (2) @(posedge hclk);
    look("sys cleared", 3'h0);
    sync_pin <= 1'b0;
    repeat (10) @(posedge hclk);
    rd("asleep", DIG_OFF_PWR, 32'h46);
    show("power pin", {30'h0, power_mode}, 32'h2);
    // Level mode, active low: the idle pin wakes; the reserved mode code is ignored.
    wr(DIG_OFF_PWR, 32'h1f);
    repeat (2) @(posedge hclk);
    rd("level wake", DIG_OFF_PWR, 32'h1c);
    repeat (2) @(posedge hclk);
    $display("test sync done");
    print_verdict();
  end
endmodule

bind dig_top dig_assertions dig_assertions_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .sample_ready(sample_ready), .fifo_ready(fifo_ready),
  .fifo_threshold(fifo_threshold), .fifo_overrun(fifo_overrun), .startup_done(startup_done),
  .irq_line_a(irq_line_a), .irq_line_b(irq_line_b), .power_mode(power_mode),
  .sync_capture(sync_capture));
